// [include/fxf_cfg.svh]
// Constants for the fixed-point to single-precision converter
`ifndef FXF_CFG_SVH
`define FXF_CFG_SVH

// ****************************************************************
// Operand format defaults and limits
// ****************************************************************
`define FXF_DW_DEFAULT    12
`define FXF_FW_DEFAULT    8
`define FXF_DW_MIN        2
`define FXF_DW_MAX        32
`define FXF_FW_MAX        23

// ****************************************************************
// Single-precision field layout
// ****************************************************************
`define FXF_SIGN_POS      31
`define FXF_EXP_MSB       30
`define FXF_EXP_LSB       23
`define FXF_MANT_W        23
`define FXF_EXP_BIAS      127
`define FXF_EXP_MAX       8'hff

// ****************************************************************
// Output buffer
// ****************************************************************
`define FXF_FIFO_DEPTH    8
`define FXF_WORD_W        32

`endif

// [include/fxf_pkg.sv]
// Types used by the converter for its two pipeline stages
package fxf_pkg;

   // ****************************************************************
   // Single-precision word as three fields, sign at the top
   // ****************************************************************
   typedef struct packed {
      logic        sign;   // Set for negative values
      logic [7:0]  exp;    // Biased exponent
      logic [22:0] mant;   // Fraction below the hidden one
   } fxf_float_t;

   // ****************************************************************
   // First stage: sign and magnitude of the operand
   // ****************************************************************
   typedef struct packed {
      logic        vld;    // Stage holds a captured operand
      logic        sign;   // Operand sign
      logic [31:0] mag;    // Absolute value, zero extended
   } fxf_stage_t;

endpackage : fxf_pkg

// [rtl/fxf_convert.sv]
// Fixed-point to single-precision converter with its output buffer
//
// Operation
// - Capture and advance only on enabled edges
// - Result appears on ieee_out two advances later and enters the buffer on the third, an advance being an enabled edge with buffer room
// - New operand accepted every enabled edge while the buffer has room
// - Output is sign, exponent, mantissa, high first
// - Value is sign, exponent less 127, one-dot-mantissa
// - Result follows single-precision standard format
// - Operand signed, fraction bits below binary point
`timescale 1ns/1ps
`include "fxf_cfg.svh"

// ****************************************************************
// Synchronous FIFO, flip-flop storage addressed by index
// ****************************************************************
module fxf_fifo #(
   parameter int WIDTH = `FXF_WORD_W,
   parameter int DEPTH = `FXF_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];    // Word storage
   logic [AW-1:0]    wr_q;             // Write index
   logic [AW-1:0]    rd_q;             // Read index
   logic [AW:0]      cnt_q;            // Words held
   logic             push;             // Word enters
   logic             pop;              // Word leaves

   // Full and empty straight from the count
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q];

   // Storage, written only at the write index
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Indices wrap at the depth
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
      end
   end

   // Occupancy, push and pop together leave it alone
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (push && !pop) begin
         cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_fifo_no_over : assert property (cnt_q <= (AW+1)'(DEPTH))
      else $error("FIFO count above depth");
   a_fifo_count : assert property (
      push && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("FIFO count missed a push");
   c_fifo_full : cover property (!in_ready);

endmodule : fxf_fifo

// ****************************************************************
// Converter top: two register levels, then the output buffer
// ****************************************************************
module fxf_convert #(
   parameter int DW = `FXF_DW_DEFAULT,     // operand_width
   parameter int FW = `FXF_FW_DEFAULT      // fraction_bit_count
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rstn,
   // Operand side
   input  wire logic          en,
   input  wire logic [DW-1:0] fixed_in,
   output logic               in_ready,
   // Direct pipeline result
   output logic [31:0]        ieee_out,
   output logic               ieee_valid,
   // Buffered result stream
   output logic               out_valid,
   input  wire logic          out_ready,
   output logic [31:0]        out_data
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Position of the highest set bit, zero when none is set
   function automatic logic [4:0] lead_pos(input logic [31:0] v);
      logic [4:0] p;
      p = '0;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) begin
            p = 5'(i);
         end
      end
      return p;
   endfunction : lead_pos

   // Absolute value of the operand, most negative fits unsigned
   function automatic logic [31:0] abs_of(input logic [DW-1:0] x);
      logic [DW-1:0] a;
      a = x[DW-1] ? (~x + 1'b1) : x;
      return 32'(a);
   endfunction : abs_of

   // ****************************************************************
   // Reset release through two flip-flops
   // ****************************************************************
   logic [1:0] rst_sync_q;                 // Release shift chain
   logic       rst_n_s;                    // Released reset

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n_s = rst_sync_q[1];

   // ****************************************************************
   // Advance control
   // ****************************************************************
   fxf_pkg::fxf_stage_t s1_q;              // Sign and magnitude
   fxf_pkg::fxf_float_t res_q;             // Packed result
   fxf_pkg::fxf_float_t res_d;             // Next result
   logic                res_vld_q;         // Result register filled
   logic                fifo_ready;        // Buffer has room
   logic                adv;               // Pipeline moves this edge

   // A full buffer stalls the whole pipe, so no result is ever dropped;
   // the cost is that en alone no longer decides the advance.
   assign adv      = en && fifo_ready;
   assign in_ready = fifo_ready;

   // ****************************************************************
   // Stage one: capture operand as sign and magnitude
   // ****************************************************************
   // capture on advance
   always_ff @(posedge clock or negedge rst_n_s) begin
      if (!rst_n_s) begin
         s1_q <= '0;
      end else if (adv) begin
         s1_q.vld  <= 1'b1;
         s1_q.sign <= fixed_in[DW-1];
         s1_q.mag  <= abs_of(fixed_in);
      end
   end

   // ****************************************************************
   // Stage two: normalise and pack
   // ****************************************************************
   logic [4:0]  pos;                       // Leading one of magnitude
   logic [63:0] norm;                      // Leading one at bit 63

   assign pos  = lead_pos(s1_q.mag);
   assign norm = 64'(s1_q.mag) << (6'd63 - 6'(pos));

   // Bits below the hidden one are truncated, never rounded
   always_comb begin
      res_d = '0;
      if (s1_q.mag != '0) begin
         res_d.sign = s1_q.sign;
         res_d.exp  = 8'(`FXF_EXP_BIAS + 32'(pos) - FW);
         res_d.mant = norm[62:40];
      end
   end

   always_ff @(posedge clock or negedge rst_n_s) begin
      if (!rst_n_s) begin
         res_q     <= '0;
         res_vld_q <= 1'b0;
      end else if (adv) begin
         res_q     <= res_d;
         res_vld_q <= s1_q.vld;
      end
   end

   assign ieee_out   = res_q;
   assign ieee_valid = res_vld_q;

   // ****************************************************************
   // Output buffer
   // ****************************************************************
   // one result per advance once the result register is filled
   fxf_fifo #(
      .WIDTH (`FXF_WORD_W),
      .DEPTH (`FXF_FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n_s),
      .in_valid  (adv && res_vld_q),
      .in_ready  (fifo_ready),
      .in_data   (ieee_out),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n_s);

   a_capture_gate : assert property (!adv |=> $stable(s1_q))
      else $error("Stage one moved without advance");
   a_hold_stall : assert property (!adv |=> $stable(ieee_out))
      else $error("Output moved while stalled");
   a_two_cycle : assert property (
      adv ##1 adv |=> ieee_out[31] ==
         ($past(fixed_in[DW-1], 2) && $past(fixed_in, 2) != '0))
      else $error("Sign not two advances after capture");
   a_back_back : assert property (
      adv ##1 adv ##1 adv |-> ieee_valid)
      else $error("Pipeline not filled by back to back operands");
   a_zero_pos : assert property (
      adv && fixed_in == '0 ##1 adv |=> ieee_out == 32'h0)
      else $error("Zero operand not positive zero");
   a_exp_bias : assert property (
      adv && fixed_in != '0 ##1 adv |=> ieee_out[30:23] ==
         8'(`FXF_EXP_BIAS + 32'(lead_pos(abs_of($past(fixed_in, 2)))) - FW))
      else $error("Exponent bias wrong");
   a_field_range : assert property (
      ieee_out[30:0] != '0 |-> ieee_out[30:23] != 8'h0 &&
         ieee_out[30:23] != `FXF_EXP_MAX)
      else $error("Nonzero result has reserved exponent");
   a_mant_bits : assert property (
      adv && fixed_in != '0 ##1 adv |=> ieee_out[22:0] ==
         23'((64'(abs_of($past(fixed_in, 2))) <<
         (6'd63 - 6'(lead_pos(abs_of($past(fixed_in, 2)))))) >> 40))
      else $error("Mantissa field misplaced");
   a_signed_in : assert property (
      adv |=> s1_q.sign == $past(fixed_in[DW-1]))
      else $error("Operand sign not taken from top bit");
   // A word offered but not taken must stay put for the consumer
   a_out_hold : assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("Buffered word changed before it was taken");

   c_negative : cover property (adv ##1 adv ##1 ieee_out[31]);
   c_stall : cover property (en && !fifo_ready);
   c_zero : cover property (adv && fixed_in == '0 ##1 adv ##1 ieee_out == 0);
   c_drain : cover property (out_valid && out_ready);

endmodule : fxf_convert

// [dv/fxf_sink.sv]
// Downstream consumer model for the buffered result stream
`timescale 1ns/1ps

module fxf_sink (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Pacing from the bench
   input  wire logic        stall,
   input  wire logic        slow,
   // Buffered stream
   input  wire logic        out_valid,
   output logic             out_ready,
   input  wire logic [31:0] out_data
);
   logic [31:0] got[$];  // Words taken, in arrival order

   // ********
   // Take words and pace ready: off, every other cycle, or always
   // ********
   // Ready only moves just after an edge, so the handshake is clean
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         out_ready <= 1'b0;
      end else begin
         if (out_valid && out_ready) begin
            got.push_back(out_data);
         end
         out_ready <= !stall && !(slow && out_ready);
      end
   end
endmodule : fxf_sink

// [dv/fixed_point_to_float32_tb.sv]
// Self-checking bench for the fixed-point to single-precision converter
`timescale 1ns/1ps

module fixed_point_to_float32_tb;
   localparam int DW = 12;  // Operand width under test
   localparam int FW = 8;   // Fraction bits under test

   logic          clock = 1'b0;  // 20 MHz clock
   logic          rstn = 1'b0;   // Active-low reset
   logic          en = 1'b0;     // Clock enable
   logic [DW-1:0] fixed_in = '0; // Operand
   logic          stall = 1'b0;  // Sink holds ready low
   logic          slow = 1'b0;   // Sink ready every other cycle
   logic          in_ready, ieee_valid, out_valid, out_ready;
   logic [31:0]   ieee_out, out_data, last_q, exp_q[$];
   logic [DW-1:0] s1, smp;       // Operand in stage one, operand at the edge
   logic [7:0]    int_in = '0;   // Integer operand, no fraction bits
   logic [31:0]   int_out;       // Integer instance result
   logic          have1 = 1'b0, adv;
   int            error_cnt = 0, samples_checked = 0, cycles = 0;

   always #25 clock = ~clock;

   // Widths within the legal ranges for width and fraction
   fxf_convert #(.DW(DW), .FW(FW)) uut (
      .clock(clock), .rstn(rstn), .en(en), .fixed_in(fixed_in),
      .in_ready(in_ready), .ieee_out(ieee_out), .ieee_valid(ieee_valid),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

   // Integer format: the whole word sits above the binary point
   fxf_convert #(.DW(8), .FW(0)) uut_int (
      .clock(clock), .rstn(rstn), .en(en), .fixed_in(int_in),
      .in_ready(), .ieee_out(int_out), .ieee_valid(),
      .out_valid(), .out_ready(1'b1), .out_data());

   fxf_sink sink (.clock(clock), .rstn(rstn), .stall(stall), .slow(slow),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

   // Reference encoding: sign, biased exponent, truncated fraction
   function automatic logic [31:0] to_f(input logic [DW-1:0] v);
      logic [31:0] m;
      int          p;
      m = 32'(signed'(v));
      if (v[DW-1]) m = -m;
      if (m == 0) return 32'h0;
      for (int i = 0; i < 32; i++) if (m[i]) p = i;
      m = (p >= 23) ? (m >> (p - 23)) : (m << (23 - p));
      return {v[DW-1], 8'(p + 127 - FW), m[22:0]};
   endfunction : to_f

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // One cycle of stimulus, launched at the rising edge
   task automatic step(input logic e, input logic [DW-1:0] v);
      @(posedge clock);
      en <= e;
      fixed_in <= v;
   endtask : step

   // ********
   // Pipeline watcher: latency, hold and expected stream order
   // ********
   always @(posedge clock) begin
      adv = rstn && en && in_ready;
      // Operand as the design samples it, before this edge's updates
      smp = fixed_in;
      #1;
      if (adv) begin
         if (have1) begin
            check("ieee_out", ieee_out, to_f(s1));
            check("ieee_valid", ieee_valid, 1);
            exp_q.push_back(to_f(s1));
         end
         s1 = smp;
         have1 = 1'b1;
      end else if (rstn) begin
         check("ieee_out hold", ieee_out, last_q);
      end
      last_q = ieee_out;
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic t_reset;
      check("in_ready", in_ready, 1);
      check("ieee_valid", ieee_valid, 0);
      check("out_valid", out_valid, 0);
      check("ieee_out", ieee_out, 0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_walk;
      step(1, 12'h80d);
      step(1, 12'h7c0);
      step(1, 12'h7c0);
      #1 check("first result", ieee_out, to_f(12'h80d));
      step(0, 12'h7c0);
      #1 check("second result", ieee_out, to_f(12'h7c0));
      $display("test walk done");
   endtask : t_walk

   task automatic t_hold;
      logic [31:0] saved;
      step(0, 12'h456);
      #1 saved = ieee_out;
      repeat (4) begin
         step(0, 12'h9ab);
         #1 check("held output", ieee_out, saved);
      end
      step(1, 12'h000);
      step(1, 12'h000);
      step(1, 12'h000);
      #1 check("zero result", ieee_out, 32'h0);
      $display("test hold done");
   endtask : t_hold

   // Boundaries of sign, exponent and fraction; watcher judges each
   task automatic t_table;
      logic [DW-1:0] vals[9];
      vals = '{12'h800, 12'h7ff, 12'h001, 12'hfff, 12'h100, 12'h080,
               12'h000, 12'h80d, 12'h7c0};
      slow <= 1'b1;
      foreach (vals[i]) step(1, vals[i]);
      step(1, 12'h000);
      step(0, 12'h000);
      #1 check("table result", ieee_out, to_f(12'h7c0));
      $display("test table done");
   endtask : t_table

   task automatic t_full;
      stall <= 1'b1;
      slow <= 1'b0;
      for (int i = 0; i < 14; i++) step(1, 12'(12'h0c3 + 12'(i * 37)));
      #1 check("in_ready full", in_ready, 0);
      check("out_valid full", out_valid, 1);
      step(1, 12'h3a5);
      stall <= 1'b0;
      repeat (12) step(0, 12'h3a5);
      #1 check("in_ready drained", in_ready, 1);
      $display("test full done");
   endtask : t_full

   task automatic t_drain;
      repeat (12) step(0, 12'h000);
      #1 check("out_valid empty", out_valid, 0);
      check("word count", sink.got.size(), exp_q.size() - 1);
      foreach (sink.got[i]) begin
         check("stream word", sink.got[i], exp_q[i]);
      end
      $display("test drain done");
   endtask : t_drain

   // Integer instance: two operands, each result two advances later
   task automatic t_int;
      @(posedge clock);
      en <= 1'b1;
      int_in <= 8'h85;
      @(posedge clock);
      int_in <= 8'h07;
      @(posedge clock);
      int_in <= 8'h00;
      #1 check("integer first", int_out, 32'hc2f60000);
      @(posedge clock);
      en <= 1'b0;
      #1 check("integer second", int_out, 32'h40e00000);
      $display("test int done");
   endtask : t_int

   initial begin
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      #1 t_reset();
      t_walk();
      t_hold();
      t_table();
      t_full();
      t_drain();
      t_int();
      wrap_up();
   end
endmodule : fixed_point_to_float32_tb
